/* File: design/ascii_pod_command_front_end.sv */
// ascii command front end: framing, pod selection, select reply, command forwarding
`timescale 1ns/100ps
module ascii_pod_command_front_end (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial bus
    input wire logic rx_in,
    output logic tx_out,
    output logic tx_oe_n,
    // configuration and events
    input wire logic [7:0] pod_addr,
    input wire logic change_event,
    // command characters to the executor
    output logic cmd_valid,
    output logic [6:0] cmd_char,
    output logic cmd_end,
    output logic cmd_abort,
    // response characters from the executor
    input wire logic resp_valid,
    input wire logic [6:0] resp_char,
    output logic resp_ack,
    // status
    output logic pod_enabled
);
    import pod_cmd_pkg::*;

    char_if rx_link ();
    char_if tx_link ();

    parse_state_t state_reg, state_next;
    logic selected_reg, selected_next;
    logic [3:0] hi_reg, hi_next;
    logic [3:0] lo_reg, lo_next;
    logic [7:0] len_reg, len_next;
    logic change_reg, change_next;
    logic reply_busy_reg, reply_busy_next;
    logic [1:0] reply_idx_reg, reply_idx_next;
    logic [7:0] reply_addr_reg, reply_addr_next;
    logic reply_y_reg, reply_y_next;
    logic tx_valid_reg, tx_valid_next;
    logic [6:0] tx_data_reg, tx_data_next;
    logic cmd_valid_reg, cmd_valid_next;
    logic [6:0] cmd_char_reg, cmd_char_next;
    logic cmd_end_reg, cmd_end_next;
    logic cmd_abort_reg, cmd_abort_next;
    logic resp_ack_reg, resp_ack_next;
    logic enabled_reg, enabled_next;
    logic addressed;
    logic enabled;
    logic [6:0] c;
    logic [4:0] hv;
    logic [7:0] sel_addr;

    ////////////////////////////////////////////////////////////////////////////
    // serial engines

    serial_rx u_rx (
        .clk (clk),
        .rst (rst),
        .rx_in (rx_in),
        .out (rx_link.src)
    );

    serial_tx u_tx (
        .clk (clk),
        .rst (rst),
        .in (tx_link.snk),
        .tx_out (tx_out),
        .tx_oe_n (tx_oe_n)
    );

    // the parser never stalls: one character per frame is far below its rate
    assign rx_link.ready = 1'b1;
    assign tx_link.valid = tx_valid_reg;
    assign tx_link.data = tx_data_reg;
    assign tx_link.err = 1'b0;

    assign cmd_valid = cmd_valid_reg;
    assign cmd_char = cmd_char_reg;
    assign cmd_end = cmd_end_reg;
    assign cmd_abort = cmd_abort_reg;
    assign resp_ack = resp_ack_reg;
    assign pod_enabled = enabled_reg;

    ////////////////////////////////////////////////////////////////////////////
    // mode

    assign addressed = (pod_addr != DEFAULT_ADDR);
    assign enabled = !addressed || selected_reg;
    assign c = rx_link.data;
    assign hv = hex_value(c);
    assign sel_addr = {hi_reg, lo_reg};

    ////////////////////////////////////////////////////////////////////////////
    // parser, reply sequencer and transmit arbitration

    always_comb begin
        state_next = state_reg;
        selected_next = selected_reg;
        hi_next = hi_reg;
        lo_next = lo_reg;
        len_next = len_reg;
        // a change arriving with the select still counts for the reply that this select starts
        change_next = change_reg || change_event;
        reply_busy_next = reply_busy_reg;
        reply_idx_next = reply_idx_reg;
        reply_addr_next = reply_addr_reg;
        reply_y_next = reply_y_reg;
        tx_valid_next = tx_valid_reg && !tx_link.ready;
        tx_data_next = tx_data_reg;
        cmd_valid_next = 1'b0;
        cmd_char_next = cmd_char_reg;
        cmd_end_next = 1'b0;
        cmd_abort_next = 1'b0;
        resp_ack_next = 1'b0;

        // one load per free slot; the select reply goes ahead of executor text
        if (!tx_valid_reg) begin
            if (reply_busy_reg) begin
                tx_valid_next = 1'b1;
                case (reply_idx_reg)
                    2'h0: tx_data_next = nib_to_hex(reply_addr_reg[7:4]);
                    2'h1: tx_data_next = nib_to_hex(reply_addr_reg[3:0]);
                    2'h2: tx_data_next = reply_y_reg ? CHAR_Y : CHAR_N;
                    default: tx_data_next = CHAR_CR;
                endcase
                reply_idx_next = reply_idx_reg + REPLY_ONE;
                if (reply_idx_reg == REPLY_LAST) begin
                    reply_busy_next = 1'b0;
                end
            end else if (resp_valid && !resp_ack_reg) begin
                resp_ack_next = 1'b1;
                // a deselected pod stays silent; its executor text is dropped
                if (enabled) begin
                    tx_valid_next = 1'b1;
                    tx_data_next = resp_char;
                end
            end
        end

        if (rx_link.valid) begin
            len_next = len_reg + LEN_ONE;
            if (rx_link.err) begin
                if (state_reg == P_BODY) begin
                    cmd_abort_next = 1'b1;
                end
                state_next = P_DISCARD;
            end else begin
                case (state_reg)
                    P_IDLE: begin
                        len_next = LEN_ONE;
                        if (c == CHAR_BANG && addressed) begin
                            state_next = P_SEL_H;
                        end else if (enabled) begin
                            cmd_valid_next = 1'b1;
                            cmd_char_next = c;
                            if (c == CHAR_CR) begin
                                cmd_end_next = 1'b1;
                            end else begin
                                state_next = P_BODY;
                            end
                        end else if (c != CHAR_CR) begin
                            state_next = P_DISCARD;
                        end
                    end
                    P_SEL_H: begin
                        hi_next = hv[3:0];
                        state_next = hv[4] ? P_SEL_L : P_DISCARD;
                        if (c == CHAR_CR) begin
                            state_next = P_IDLE;
                        end
                    end
                    P_SEL_L: begin
                        lo_next = hv[3:0];
                        state_next = hv[4] ? P_SEL_CR : P_DISCARD;
                        if (c == CHAR_CR) begin
                            state_next = P_IDLE;
                        end
                    end
                    P_SEL_CR: begin
                        if (c == CHAR_CR) begin
                            state_next = P_IDLE;
                            // address 00 is no valid select target
                            if (sel_addr != DEFAULT_ADDR) begin
                                if (sel_addr == pod_addr) begin
                                    selected_next = 1'b1;
                                    reply_busy_next = 1'b1;
                                    reply_idx_next = 2'h0;
                                    reply_addr_next = pod_addr;
                                    reply_y_next = change_reg || change_event;
                                    change_next = 1'b0;
                                end else begin
                                    selected_next = 1'b0;
                                end
                            end
                        end else begin
                            state_next = P_DISCARD;
                        end
                    end
                    P_BODY: begin
                        if (c == CHAR_CR) begin
                            cmd_valid_next = 1'b1;
                            cmd_char_next = c;
                            cmd_end_next = 1'b1;
                            state_next = P_IDLE;
                        end else if (len_reg >= MSG_LIMIT) begin
                            // overlong text is never handed on as a command
                            cmd_abort_next = 1'b1;
                            state_next = P_DISCARD;
                        end else begin
                            cmd_valid_next = 1'b1;
                            cmd_char_next = c;
                        end
                    end
                    P_DISCARD: begin
                        if (c == CHAR_CR) begin
                            state_next = P_IDLE;
                        end
                    end
                    default: state_next = P_IDLE;
                endcase
            end
        end
        enabled_next = !(pod_addr != DEFAULT_ADDR) || selected_next;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= P_IDLE;
            selected_reg <= 1'b0;
            hi_reg <= 4'h0;
            lo_reg <= 4'h0;
            len_reg <= 8'h00;
            change_reg <= 1'b0;
            reply_busy_reg <= 1'b0;
            reply_idx_reg <= 2'h0;
            reply_addr_reg <= 8'h00;
            reply_y_reg <= 1'b0;
            tx_valid_reg <= 1'b0;
            tx_data_reg <= 7'h00;
            cmd_valid_reg <= 1'b0;
            cmd_char_reg <= 7'h00;
            cmd_end_reg <= 1'b0;
            cmd_abort_reg <= 1'b0;
            resp_ack_reg <= 1'b0;
            enabled_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            selected_reg <= selected_next;
            hi_reg <= hi_next;
            lo_reg <= lo_next;
            len_reg <= len_next;
            change_reg <= change_next;
            reply_busy_reg <= reply_busy_next;
            reply_idx_reg <= reply_idx_next;
            reply_addr_reg <= reply_addr_next;
            reply_y_reg <= reply_y_next;
            tx_valid_reg <= tx_valid_next;
            tx_data_reg <= tx_data_next;
            cmd_valid_reg <= cmd_valid_next;
            cmd_char_reg <= cmd_char_next;
            cmd_end_reg <= cmd_end_next;
            cmd_abort_reg <= cmd_abort_next;
            resp_ack_reg <= resp_ack_next;
            enabled_reg <= enabled_next;
        end
    end
endmodule

/* File: design/pod_cmd_pkg.sv */
// shared constants, types and helpers of the ascii pod command front end
package pod_cmd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_HZ = 25_000_000;
    localparam int BAUD_DEFAULT = 9600;
    localparam int BIT_CYCLES_INT = CLK_HZ / BAUD_DEFAULT;
    localparam logic [11:0] BIT_CYCLES = 12'(BIT_CYCLES_INT);
    localparam logic [11:0] HALF_BIT_CYCLES = 12'(BIT_CYCLES_INT / 2);
    localparam logic [11:0] CNT_ONE = 12'h001;

    ////////////////////////////////////////////////////////////////////////////
    // character framing
    localparam int DATA_BITS = 7;
    localparam logic [3:0] RX_SAMPLE_BITS = 4'h9;
    localparam logic [3:0] TX_FRAME_BITS = 4'hA;
    localparam logic [3:0] BIT_IDX_ONE = 4'h1;

    ////////////////////////////////////////////////////////////////////////////
    // characters and addresses
    localparam logic [6:0] CHAR_CR = 7'h0D;
    localparam logic [6:0] CHAR_BANG = 7'h21;
    localparam logic [6:0] CHAR_Y = 7'h59;
    localparam logic [6:0] CHAR_N = 7'h4E;
    localparam logic [6:0] CHAR_0 = 7'h30;
    localparam logic [6:0] CHAR_9 = 7'h39;
    localparam logic [6:0] CHAR_UA = 7'h41;
    localparam logic [6:0] CHAR_UF = 7'h46;
    localparam logic [6:0] ALPHA_BASE = 7'h37;
    localparam logic [7:0] DEFAULT_ADDR = 8'h00;
    localparam logic [7:0] MSG_LIMIT = 8'hFE;
    localparam logic [7:0] LEN_ONE = 8'h01;
    localparam logic [1:0] REPLY_LAST = 2'h3;
    localparam logic [1:0] REPLY_ONE = 2'h1;

    ////////////////////////////////////////////////////////////////////////////
    // states
    typedef enum logic [2:0] {P_IDLE, P_SEL_H, P_SEL_L, P_SEL_CR, P_BODY, P_DISCARD} parse_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_t;
    typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // upper case hex only: lower case letters are different characters
    function automatic logic [4:0] hex_value(input logic [6:0] c);
        logic [6:0] v;
        v = 7'h00;
        if (c >= CHAR_0 && c <= CHAR_9) begin
            v = c - CHAR_0;
            return {1'b1, v[3:0]};
        end
        if (c >= CHAR_UA && c <= CHAR_UF) begin
            v = c - ALPHA_BASE;
            return {1'b1, v[3:0]};
        end
        return 5'h00;
    endfunction

    function automatic logic [6:0] nib_to_hex(input logic [3:0] n);
        logic [6:0] w;
        w = {3'h0, n};
        if (n > 4'h9) begin
            return w + ALPHA_BASE;
        end
        return w + CHAR_0;
    endfunction

endpackage

/* File: design/char_if.sv */
// character link between the serial engines and the command parser
`timescale 1ns/100ps
interface char_if;
    logic valid;
    logic ready;
    logic err;
    logic [6:0] data;
    modport src (output valid, output err, output data, input ready);
    modport snk (input valid, input err, input data, output ready);
endinterface

/* File: design/serial_rx.sv */
// serial receiver: 7 data bits, even parity, 1 stop bit
`timescale 1ns/100ps
module serial_rx (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // line
    input wire logic rx_in,
    // received characters
    char_if.src out
);
    import pod_cmd_pkg::*;

    logic sync1_reg, sync2_reg;
    rx_state_t state_reg, state_next;
    logic [11:0] cnt_reg, cnt_next;
    logic [3:0] idx_reg, idx_next;
    logic [8:0] shift_reg, shift_next;
    logic valid_reg, valid_next;
    logic err_reg, err_next;
    logic [6:0] data_reg, data_next;
    logic [8:0] frame;

    assign out.valid = valid_reg;
    assign out.err = err_reg;
    assign out.data = data_reg;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        idx_next = idx_reg;
        shift_next = shift_reg;
        valid_next = valid_reg && !out.ready;
        err_next = err_reg;
        data_next = data_reg;
        frame = {sync2_reg, shift_reg[8:1]};
        case (state_reg)
            RX_IDLE: begin
                if (!sync2_reg) begin
                    state_next = RX_START;
                    cnt_next = HALF_BIT_CYCLES;
                end
            end
            RX_START: begin
                if (cnt_reg == CNT_ONE) begin
                    // a glitch shorter than half a bit is not a start bit
                    state_next = sync2_reg ? RX_IDLE : RX_DATA;
                    cnt_next = BIT_CYCLES;
                    idx_next = RX_SAMPLE_BITS;
                end else begin
                    cnt_next = cnt_reg - CNT_ONE;
                end
            end
            RX_DATA: begin
                if (cnt_reg == CNT_ONE) begin
                    cnt_next = BIT_CYCLES;
                    shift_next = frame;
                    idx_next = idx_reg - BIT_IDX_ONE;
                    if (idx_reg == BIT_IDX_ONE) begin
                        state_next = RX_IDLE;
                        valid_next = 1'b1;
                        data_next = frame[DATA_BITS-1:0];
                        err_next = (^frame[DATA_BITS:0]) || !frame[8];
                    end
                end else begin
                    cnt_next = cnt_reg - CNT_ONE;
                end
            end
            default: state_next = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            state_reg <= RX_IDLE;
            cnt_reg <= 12'h000;
            idx_reg <= 4'h0;
            shift_reg <= 9'h000;
            valid_reg <= 1'b0;
            err_reg <= 1'b0;
            data_reg <= 7'h00;
        end else begin
            sync1_reg <= rx_in;
            sync2_reg <= sync1_reg;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            idx_reg <= idx_next;
            shift_reg <= shift_next;
            valid_reg <= valid_next;
            err_reg <= err_next;
            data_reg <= data_next;
        end
    end
endmodule

/* File: design/serial_tx.sv */
// serial transmitter: 7 data bits, even parity, 1 stop bit, bus driver enable
`timescale 1ns/100ps
module serial_tx (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // characters to send
    char_if.snk in,
    // line
    output logic tx_out,
    output logic tx_oe_n
);
    import pod_cmd_pkg::*;

    tx_state_t state_reg, state_next;
    logic [11:0] cnt_reg, cnt_next;
    logic [3:0] idx_reg, idx_next;
    logic [9:0] shift_reg, shift_next;
    logic line_reg, line_next;
    logic oe_n_reg, oe_n_next;

    assign in.ready = (state_reg == TX_IDLE);
    assign tx_out = line_reg;
    assign tx_oe_n = oe_n_reg;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        idx_next = idx_reg;
        shift_next = shift_reg;
        line_next = line_reg;
        oe_n_next = oe_n_reg;
        case (state_reg)
            TX_IDLE: begin
                line_next = 1'b1;
                oe_n_next = 1'b1;
                if (in.valid) begin
                    // stop, even parity, data lsb first, start
                    shift_next = {1'b1, ^in.data, in.data, 1'b0};
                    state_next = TX_SHIFT;
                    cnt_next = CNT_ONE;
                    idx_next = TX_FRAME_BITS;
                end
            end
            TX_SHIFT: begin
                if (cnt_reg == CNT_ONE) begin
                    cnt_next = BIT_CYCLES;
                    if (idx_reg == 4'h0) begin
                        state_next = TX_IDLE;
                        line_next = 1'b1;
                        oe_n_next = 1'b1;
                    end else begin
                        line_next = shift_reg[0];
                        oe_n_next = 1'b0;
                        shift_next = {1'b1, shift_reg[9:1]};
                        idx_next = idx_reg - BIT_IDX_ONE;
                    end
                end else begin
                    cnt_next = cnt_reg - CNT_ONE;
                end
            end
            default: state_next = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= TX_IDLE;
            cnt_reg <= 12'h000;
            idx_reg <= 4'h0;
            shift_reg <= 10'h3FF;
            line_reg <= 1'b1;
            oe_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            idx_reg <= idx_next;
            shift_reg <= shift_next;
            line_reg <= line_next;
            oe_n_reg <= oe_n_next;
        end
    end
endmodule

/* File: testbench/pod_front_end_checker.sv */
// port assertions of the pod command front end
`timescale 1ns/100ps
module pod_front_end_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial bus
    input wire logic rx_in,
    input wire logic tx_out,
    input wire logic tx_oe_n,
    // configuration and events
    input wire logic [7:0] pod_addr,
    input wire logic change_event,
    // executor side
    input wire logic cmd_valid,
    input wire logic [6:0] cmd_char,
    input wire logic cmd_end,
    input wire logic cmd_abort,
    input wire logic resp_valid,
    input wire logic [6:0] resp_char,
    input wire logic resp_ack,
    // status
    input wire logic pod_enabled
);
    import pod_cmd_pkg::*;
    // the driver stays on through the stop bit, so a frame holds it for all ten bits
    localparam int FRAME_LOW = 10 * BIT_CYCLES_INT;
    ////////////////////////////////////////////////////////////////////////////
    // cycles the driver has been on in this frame
    logic [15:0] low_cnt_reg;
    logic [15:0] low_cnt_next;
    always_comb begin
        low_cnt_next = tx_oe_n ? 16'h0000 : low_cnt_reg + 16'h0001;
    end
    always_ff @(posedge clk) begin
        low_cnt_reg <= rst ? 16'h0000 : low_cnt_next;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_end_is_cr;
        cmd_end |-> cmd_valid && cmd_char == CHAR_CR;
    endproperty
    property p_cmd_enabled;
        cmd_valid |-> pod_enabled;
    endproperty
    property p_nonaddr;
        pod_addr == DEFAULT_ADDR |=> pod_enabled;
    endproperty
    property p_idle_high;
        tx_oe_n |-> tx_out;
    endproperty
    property p_start_low;
        $fell(tx_oe_n) |-> !tx_out ##1 !tx_out;
    endproperty
    property p_frame_len;
        $rose(tx_oe_n) |-> low_cnt_reg == 16'(FRAME_LOW);
    endproperty
    // a bit may only change on a whole bit boundary
    property p_bit_hold;
        !tx_oe_n && $changed(tx_out) |-> low_cnt_reg % BIT_CYCLES_INT == 0;
    endproperty
    property p_cmd_pulse;
        cmd_valid |=> !cmd_valid;
    endproperty
    a_end_is_cr: assert property (p_end_is_cr) else $error("cmd_end without CR");
    a_cmd_enabled: assert property (p_cmd_enabled) else $error("cmd while disabled");
    a_nonaddr: assert property (p_nonaddr) else $error("address 00 not enabled");
    a_idle_high: assert property (p_idle_high) else $error("line low while released");
    a_start_low: assert property (p_start_low) else $error("no start bit");
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
    a_bit_hold: assert property (p_bit_hold) else $error("bit changed mid bit");
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("cmd_valid too long");
    c_end: cover property (cmd_end);
    c_sel: cover property ($rose(pod_enabled) && pod_addr != DEFAULT_ADDR);
    c_frame: cover property ($rose(tx_oe_n));
endmodule

/* File: testbench/host_model.sv */
// host computer on the shared serial bus
`timescale 1ns/100ps
module host_model (
    // clock
    input wire logic clk,
    // bus as seen by the host, and the host driver
    input wire logic bus_line,
    output logic host_tx
);
    import pod_cmd_pkg::*;
    logic [8:0] got_q[$];
    logic [8:0] fr;
    // 7 data lsb first, even parity, 1 stop, fixed 9600 baud
    task automatic send_char(input logic [6:0] c);
        logic [9:0] bits;
        bits = {1'b1, ^c, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            host_tx = bits[i];
            repeat (BIT_CYCLES_INT) @(negedge clk);
        end
    endtask
    initial begin
        host_tx = 1'b1;
        forever begin
            @(negedge clk);
            if (bus_line === 1'b0) begin
                repeat (BIT_CYCLES_INT / 2) @(negedge clk);
                for (int i = 0; i < 9; i++) begin
                    repeat (BIT_CYCLES_INT) @(negedge clk);
                    fr[i] = bus_line;
                end
                got_q.push_back(fr);
            end
        end
    end
endmodule

/* File: testbench/tb.sv */
// self-checking bench of the pod command front end
`timescale 1ns/100ps
module tb;
    import pod_cmd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] pod_addr = 8'h00;
    logic change_event = 1'b0;
    logic resp_valid = 1'b0;
    logic [6:0] resp_char = 7'h00;
    logic rx_in, tx_out, tx_oe_n, cmd_valid, cmd_end, cmd_abort, resp_ack, pod_enabled;
    logic [6:0] cmd_char;
    logic [7:0] cmd_q[$];
    int mismatches = 0;
    int n_compared = 0;
    // released bus idles high through failsafe bias
    wire bus_line = tx_oe_n ? 1'b1 : tx_out;
    host_model host (.clk(clk), .bus_line(bus_line), .host_tx(rx_in));
    ascii_pod_command_front_end uut (.clk(clk), .rst(rst), .rx_in(rx_in), .tx_out(tx_out),
        .tx_oe_n(tx_oe_n), .pod_addr(pod_addr), .change_event(change_event),
        .cmd_valid(cmd_valid), .cmd_char(cmd_char), .cmd_end(cmd_end), .cmd_abort(cmd_abort),
        .resp_valid(resp_valid), .resp_char(resp_char), .resp_ack(resp_ack),
        .pod_enabled(pod_enabled));
    initial forever #20 clk = ~clk;
    always @(posedge clk) if (cmd_valid === 1'b1) cmd_q.push_back({cmd_end, cmd_char});
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check_val(input string what, input logic [8:0] exp, input logic [8:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_count(input int n, input bit host_side, input int lim);
        int k;
        k = 0;
        while ((host_side ? host.got_q.size() : cmd_q.size()) < n) begin
            @(negedge clk);
            k++;
            if (k > lim) begin
                mismatches++;
                $display("unexpected wait timeout");
                stop_test();
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check_val("tx_out", 9'h001, {8'h00, tx_out});
        check_val("pod_enabled", 9'h000, {8'h00, pod_enabled});
    endtask
    // lower case text ended by CR goes straight through as one command
    task automatic t_nonaddr;
        check_val("pod_enabled", 9'h001, {8'h00, pod_enabled});
        host.send_char(7'h61);
        host.send_char(CHAR_CR);
        wait_count(2, 1'b0, 100);
        check_val("cmd char", 9'h061, {1'b0, cmd_q.pop_front()});
        check_val("cmd end", 9'h08D, {1'b0, cmd_q.pop_front()});
    endtask
    task automatic t_resp;
        int k;
        k = 0;
        resp_char = 7'h43;
        resp_valid = 1'b1;
        while (resp_ack !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        check_val("resp_ack", 9'h001, {8'h00, resp_ack});
        resp_valid = 1'b0;
        wait_count(1, 1'b1, 30000);
        check_val("tx frame", 9'h1C3, host.got_q.pop_front());
    endtask
    // host selects first, then waits for the reply
    task automatic t_select;
        logic [6:0] exp[4];
        exp = '{7'h31, 7'h32, CHAR_Y, CHAR_CR};
        pod_addr = 8'h12;
        repeat (2) @(negedge clk);
        check_val("pod_enabled", 9'h000, {8'h00, pod_enabled});
        change_event = 1'b1;
        @(negedge clk);
        change_event = 1'b0;
        host.send_char(CHAR_BANG);
        host.send_char(7'h31);
        host.send_char(7'h32);
        host.send_char(CHAR_CR);
        wait_count(4, 1'b1, 120000);
        for (int i = 0; i < 4; i++) begin
            check_val("reply", {1'b1, ^exp[i], exp[i]}, host.got_q.pop_front());
        end
        check_val("pod_enabled", 9'h001, {8'h00, pod_enabled});
        check_val("forwarded", 9'h000, 9'(cmd_q.size()));
    endtask
    initial begin
        repeat (3) @(negedge clk);
        t_reset();
        rst = 1'b0;
        repeat (3) @(negedge clk);
        t_nonaddr();
        t_resp();
        t_select();
        stop_test();
    end
endmodule
bind ascii_pod_command_front_end pod_front_end_checker chk (.clk(clk), .rst(rst),
    .rx_in(rx_in), .tx_out(tx_out), .tx_oe_n(tx_oe_n), .pod_addr(pod_addr),
    .change_event(change_event), .cmd_valid(cmd_valid), .cmd_char(cmd_char),
    .cmd_end(cmd_end), .cmd_abort(cmd_abort), .resp_valid(resp_valid),
    .resp_char(resp_char), .resp_ack(resp_ack), .pod_enabled(pod_enabled));
